/* File: core/tpr_readout_top.sv */
// Trigger pipeline, accumulator and readout barrel buffer with APB access.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tpr_readout_top (
    // Clock and resets
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  clearN,
    // Hit stream and trigger
    input  wire logic [127:0]          hitIn,
    input  wire logic                  triggerAccept,
    input  wire logic                  accumEnable,
    // Readout side
    input  wire logic                  bufRead,
    output logic      [127:0]          bufData,
    output logic                       bufEmpty,
    output logic                       dataAvail,
    output logic                       overflowOut,
    output logic                       errorOut,
    // Register bus
    input  wire tpr_pkg::tpr_apb_req_t apbReq,
    output tpr_pkg::tpr_apb_rsp_t      apbRsp
);
    import tpr_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [7:0] pipeInc(input logic [7:0] p);
        pipeInc = (p == PIPE_LAST) ? 8'h00 : p + 8'h01;
    endfunction : pipeInc

    function automatic logic [7:0] pipeBack(input logic [7:0] p,
                                            input logic [7:0] n);
        pipeBack = (p >= n) ? p - n : p + PIPE_SIZE - n;
    endfunction : pipeBack

    function automatic logic [4:0] bufInc(input logic [4:0] p);
        bufInc = (p == BUF_LAST) ? 5'h00 : p + 5'h01;
    endfunction : bufInc

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [127:0] pipeMem [PIPE_DEPTH];
    logic [127:0] bufMem  [BUF_DEPTH];
    logic [7:0]   pipePtr_reg;
    logic [127:0] acc_reg;
    tpr_state_t   state_reg;
    logic [7:0]   copyAddr_reg;
    logic [1:0]   copyCnt_reg;
    logic         copyAcc_reg;
    logic         evtLost_reg;
    logic [4:0]   wrPtr_reg;
    logic [4:0]   rdPtr_reg;
    logic [4:0]   count_reg;
    logic [4:0]   countNext;
    logic [1:0]   rdPhase_reg;
    logic [3:0]   ovfCnt_reg;
    logic [3:0]   ovfNext;
    logic         take_reg;
    logic         soft_reg;
    logic [127:0] wrData;
    logic         wrEn;
    logic         rdOk;
    logic         overwrite;
    logic         evtRead;
    logic         ovfInc;
    logic         ovfDec;
    logic         ovfWrap;
    logic         ovfLost_reg;
    logic         apbDone;
    logic [31:0]  rdMux;
    logic         rdHit;

    // ------------------------------------------------------------------
    // Pipeline
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (take_reg) begin
            pipeMem[pipePtr_reg] <= hitIn; // see RL1 see RL2 see RL3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !clearN) begin
            pipePtr_reg <= 8'h00; // see RL9
        end else if (take_reg) begin
            pipePtr_reg <= pipeInc(pipePtr_reg); // see RL3 see RL4
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || soft_reg || !clearN) begin
            acc_reg <= '0; // see RL8 see RL9
        end else if (take_reg) begin
            acc_reg <= acc_reg | hitIn; // see RL6
        end
    end

    // ------------------------------------------------------------------
    // Trigger copy sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || !clearN) begin
            state_reg    <= ST_IDLE;
            copyAddr_reg <= 8'h00;
            copyCnt_reg  <= 2'h0;
            copyAcc_reg  <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (triggerAccept) begin
                        state_reg    <= ST_COPY;
                        // Oldest of the three bins first.
                        copyAddr_reg <= pipeBack(pipePtr_reg,
                                                 TRIG_LAT + 8'h01); // see RL24
                        copyCnt_reg  <= 2'h0;
                        copyAcc_reg  <= accumEnable; // see RL7
                    end
                end
                ST_COPY: begin
                    copyAddr_reg <= pipeInc(copyAddr_reg); // see RL5
                    copyCnt_reg  <= copyCnt_reg + 2'h1;
                    if (copyCnt_reg == EVT_LAST) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        wrEn   = (state_reg == ST_COPY); // see RL5 see RL11
        wrData = copyAcc_reg ? acc_reg : pipeMem[copyAddr_reg]; // see RL7
    end

    // ------------------------------------------------------------------
    // Readout buffer
    // ------------------------------------------------------------------
    always_comb begin
        rdOk      = bufRead && (count_reg != 5'h00); // see RL14
        overwrite = wrEn && (count_reg == BUF_FULL) && !rdOk; // see RL13
        evtRead   = rdOk && (rdPhase_reg == EVT_LAST);
        ovfInc    = overwrite && !evtLost_reg; // see RL15
        ovfDec    = evtRead && (ovfCnt_reg != 4'h0); // see RL16
        ovfWrap   = ovfInc && !ovfDec && (ovfCnt_reg == OVF_MAX); // see RL17
        countNext = count_reg;
        if (wrEn && !rdOk && !overwrite) begin
            countNext = count_reg + 5'h01;
        end else if (rdOk && !wrEn) begin
            countNext = count_reg - 5'h01;
        end
        ovfNext = ovfCnt_reg;
        if (ovfInc && !ovfDec) begin
            ovfNext = ovfCnt_reg + 4'h1;
        end else if (ovfDec && !ovfInc) begin
            ovfNext = ovfCnt_reg - 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            bufMem[wrPtr_reg] <= wrData; // see RL10 see RL22
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bufData <= '0;
        end else if (rdOk) begin
            bufData <= bufMem[rdPtr_reg]; // see RL22
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || soft_reg || !clearN) begin
            wrPtr_reg   <= 5'h00; // see RL21
            rdPtr_reg   <= 5'h00;
            count_reg   <= 5'h00;
            rdPhase_reg <= 2'h0;
        end else begin
            if (wrEn) begin
                wrPtr_reg <= bufInc(wrPtr_reg); // see RL13
            end
            // An overwrite drops the oldest word, so the reader follows.
            if (rdOk || overwrite) begin
                rdPtr_reg   <= bufInc(rdPtr_reg); // see RL22
                rdPhase_reg <= (rdPhase_reg == EVT_LAST) ? 2'h0
                                                         : rdPhase_reg + 2'h1;
            end
            count_reg <= countNext;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !clearN || state_reg == ST_IDLE) begin
            evtLost_reg <= 1'b0;
        end else if (overwrite) begin
            evtLost_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || soft_reg || !clearN) begin
            ovfCnt_reg <= 4'h0;
        end else begin
            ovfCnt_reg <= ovfNext; // see RL15 see RL16
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            errorOut <= 1'b0;
        end else if (ovfWrap) begin
            errorOut <= 1'b1; // see RL17
        end else if (soft_reg) begin
            errorOut <= 1'b0; // see RL18
        end
    end

    // A wrapped counter no longer shows that data was lost.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovfLost_reg <= 1'b0;
        end else if (ovfWrap) begin
            ovfLost_reg <= 1'b1; // see RL19
        end else if (soft_reg || !clearN) begin
            ovfLost_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || soft_reg || !clearN) begin
            bufEmpty    <= 1'b1;
            dataAvail   <= 1'b0;
            overflowOut <= 1'b0;
        end else begin
            bufEmpty    <= (countNext == 5'h00); // see RL14 see RL12
            dataAvail   <= (countNext >= EVT_WORDS); // see RL25 see RL23
            overflowOut <= (ovfNext != 4'h0) || ovfWrap
                           || ovfLost_reg; // see RL19 see RL20
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign apbDone = apbReq.psel && apbReq.penable && apbRsp.pready;

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        if (apbReq.paddr == OFS_CTRL) begin
            rdMux[CTRL_TAKE] = take_reg;
        end else if (apbReq.paddr == OFS_STATUS) begin
            rdMux[12:0] = {count_reg, ovfCnt_reg, errorOut, overflowOut,
                           dataAvail, bufEmpty};
        end else if (apbReq.paddr == OFS_PTRS) begin
            rdMux[20:0] = {rdPtr_reg, 3'h0, wrPtr_reg, pipePtr_reg};
        end else if (apbReq.paddr == OFS_ACC0) begin
            rdMux = acc_reg[31:0];
        end else if (apbReq.paddr == OFS_ACC1) begin
            rdMux = acc_reg[63:32];
        end else if (apbReq.paddr == OFS_ACC2) begin
            rdMux = acc_reg[95:64];
        end else if (apbReq.paddr == OFS_ACC3) begin
            rdMux = acc_reg[127:96];
        end else begin
            rdHit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            apbRsp <= '0;
        end else begin
            apbRsp.pready  <= apbReq.psel && apbReq.penable && !apbRsp.pready;
            apbRsp.pslverr <= apbReq.psel && apbReq.penable &&
                              !apbRsp.pready && !rdHit;
            if (apbReq.psel && apbReq.penable && !apbRsp.pready &&
                !apbReq.pwrite) begin
                apbRsp.prdata <= rdMux;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            take_reg <= CTRL_TAKE_RST;
            soft_reg <= 1'b0;
        end else begin
            soft_reg <= 1'b0;
            if (apbDone && apbReq.pwrite && apbReq.paddr == OFS_CTRL) begin
                take_reg <= apbReq.pwdata[CTRL_TAKE];
                soft_reg <= apbReq.pwdata[CTRL_SOFT]; // see RL8
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_pipe_wrap: assert property ( // see RL4
        @(posedge sys_clk) disable iff (rst)
        (clearN && take_reg && pipePtr_reg == 8'h83) |=> pipePtr_reg == 8'h00)
        else $error("pipeline pointer did not wrap");

    a_pipe_step: assert property ( // see RL3
        @(posedge sys_clk) disable iff (rst)
        (clearN && take_reg && pipePtr_reg < 8'h83)
        |=> pipePtr_reg == $past(pipePtr_reg) + 8'h01)
        else $error("pipeline pointer did not advance");

    a_copy_three: assert property ( // see RL5
        @(posedge sys_clk) disable iff (rst || !clearN)
        (state_reg == ST_IDLE && triggerAccept) |=> wrEn [*3] ##1 !wrEn)
        else $error("trigger did not write three words");

    a_acc_sticky: assert property ( // see RL6
        @(posedge sys_clk) disable iff (rst)
        (clearN && !soft_reg)
        |=> (acc_reg & $past(acc_reg)) == $past(acc_reg))
        else $error("accumulator bit lost");

    a_acc_clear: assert property ( // see RL9
        @(posedge sys_clk) disable iff (rst)
        !clearN |=> acc_reg == '0 && pipePtr_reg == 8'h00
                    && wrPtr_reg == 5'h00 && rdPtr_reg == 5'h00)
        else $error("clear did not reset pipeline and buffer");

    a_rd_blocked: assert property ( // see RL14
        @(posedge sys_clk) disable iff (rst || !clearN || soft_reg)
        (count_reg == 5'h00 && bufRead && !wrEn)
        |=> rdPtr_reg == $past(rdPtr_reg) && bufEmpty)
        else $error("read passed the write pointer");

    a_err_hold: assert property ( // see RL18
        @(posedge sys_clk) disable iff (rst)
        (errorOut && !soft_reg) |=> errorOut)
        else $error("error flag dropped without reset");

    a_ovf_floor: assert property ( // see RL16
        @(posedge sys_clk) disable iff (rst || !clearN || soft_reg)
        (ovfCnt_reg == 4'h0 && !ovfInc) |=> ovfCnt_reg == 4'h0)
        else $error("overflow counter went below zero");

    a_err_set: assert property ( // see RL17
        @(posedge sys_clk) disable iff (rst || soft_reg)
        (ovfCnt_reg == 4'hf && ovfInc && !ovfDec && clearN)
        |=> errorOut && ovfCnt_reg == 4'h0)
        else $error("counter overflow did not set error");

    a_avail_full: assert property ( // see RL25
        @(posedge sys_clk) disable iff (rst)
        dataAvail |-> count_reg >= 5'h03 && !bufEmpty)
        else $error("data available without a full event");

    a_ovf_flag: assert property ( // see RL13
        @(posedge sys_clk) disable iff (rst || !clearN || soft_reg)
        ovfInc |=> overflowOut)
        else $error("overwrite did not raise overflow");

    a_ovf_count: assert property ( // see RL15
        @(posedge sys_clk) disable iff (rst || !clearN || soft_reg)
        ovfInc |=> ovfCnt_reg == $past(ovfCnt_reg) + 4'h1)
        else $error("overflow counter did not count up");

    a_ovf_dec: assert property ( // see RL16
        @(posedge sys_clk) disable iff (rst || !clearN || soft_reg)
        (evtRead && ovfCnt_reg != 4'h0)
        |=> ovfCnt_reg == $past(ovfCnt_reg) - 4'h1)
        else $error("overflow counter did not count down");

    a_empty_set: assert property ( // see RL14
        @(posedge sys_clk) disable iff (rst || !clearN || soft_reg)
        (count_reg == 5'h01 && rdOk && !wrEn) |=> bufEmpty)
        else $error("buffer not empty after last read");

    a_wr_wrap: assert property ( // see RL13
        @(posedge sys_clk) disable iff (rst || !clearN || soft_reg)
        (wrEn && wrPtr_reg == 5'h17) |=> wrPtr_reg == 5'h00)
        else $error("write pointer did not wrap");

endmodule : tpr_readout_top
`default_nettype wire

/* File: pkg/tpr_pkg.sv */
// Constants and types for the trigger pipeline and readout buffer.
// Summary of operation
// RL1: Pipeline memory 128 bits by 132 words.
// RL2: Pipeline writes once per 40 MHz clock.
// RL3: Taking data stores word, advances pointer.
// RL4: Pipeline pointer wraps from 131 to zero.
// RL5: Trigger copies bin, previous and next words.
// RL6: Accumulator bit sticks once channel hit.
// RL7: Accumulator mode writes accumulator three times.
// RL8: Power-up or soft reset clears accumulator.
// RL9: Clear low resets pipeline pointer, accumulator.
// RL10: Readout buffer holds 24 words, 128 bits.
// RL11: Three crossing bits per channel per trigger.
// RL12: Downstream starts events only when not empty.
// RL13: Writer may overwrite; wraps; overwrite flags overflow.
// RL14: Reader never passes writer; equal means empty.
// RL15: Overflow counter counts events written while full.
// RL16: Counter decrements per event read, floor zero.
// RL17: Counter overflow after 16 events sets error.
// RL18: Error holds until soft or power-up reset.
// RL19: Overflow output beyond 8 events stored.
// RL20: Readout reports lost data on overflow.
// RL21: Clear low resets buffer read, write pointers.
// RL22: Write strobe stores, read strobe presents, advances.
// RL23: Compression pops three words per event.
// RL24: Selected bin fixed offset behind write pointer.
// RL25: Data available when full event stored.
package tpr_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int       HIT_W      = 128;
    localparam int       PIPE_DEPTH = 132;
    localparam logic [7:0] PIPE_LAST  = 8'h83;
    localparam logic [7:0] PIPE_SIZE  = 8'h84;
    localparam int       BUF_DEPTH  = 24;
    localparam logic [4:0] BUF_LAST   = 5'h17;
    localparam logic [4:0] BUF_FULL   = 5'h18;
    localparam logic [1:0] EVT_LAST   = 2'h2;
    localparam logic [4:0] EVT_WORDS  = 5'h03;
    localparam logic [3:0] OVF_MAX    = 4'hf;
    localparam logic [7:0] TRIG_LAT   = 8'h04;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_PTRS   = 12'h008;
    localparam logic [11:0] OFS_ACC0   = 12'h010;
    localparam logic [11:0] OFS_ACC1   = 12'h014;
    localparam logic [11:0] OFS_ACC2   = 12'h018;
    localparam logic [11:0] OFS_ACC3   = 12'h01c;
    localparam int          CTRL_TAKE  = 0;
    localparam int          CTRL_SOFT  = 1;
    localparam logic        CTRL_TAKE_RST = 1'h1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tpr_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tpr_apb_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_COPY = 2'b10
    } tpr_state_t;

endpackage : tpr_pkg

/* File: tb/tpr_consumer_model.sv */
// Behavioural model of the compression logic that drains the readout buffer.
`timescale 1ns/1ps
`default_nettype none
module tpr_consumer_model (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // Bench control
    input  wire logic               enable,
    input  wire logic               slow,
    // Buffer side
    input  wire logic               dataAvail,
    input  wire logic               bufEmpty,
    input  wire logic               overflowOut,
    input  wire logic [127:0]       bufData,
    output logic                    bufRead,
    // Captured event
    output logic [2:0][127:0]       evt,
    output logic [7:0]              evtCount,
    output logic                    lostSeen
);
    logic       busy;
    logic       rdPrev;
    logic [1:0] nIss;
    logic [1:0] nGot;

    // ------------------------------------------------------------------
    // Event pop sequence
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy     <= 1'b0;
            rdPrev   <= 1'b0;
            bufRead  <= 1'b0;
            nIss     <= 2'h0;
            nGot     <= 2'h0;
            evtCount <= 8'h00;
            lostSeen <= 1'b0;
        end else begin
            rdPrev <= bufRead;
            if (rdPrev) begin
                evt[nGot] <= bufData;
                nGot      <= nGot + 2'h1;
            end
            if (!busy && enable && dataAvail && !bufEmpty) begin
                busy     <= 1'b1;
                lostSeen <= overflowOut;
                bufRead  <= 1'b1;
                nIss     <= 2'h1;
                nGot     <= 2'h0;
            end else if (busy) begin
                if (bufRead && slow) begin
                    bufRead <= 1'b0;
                end else if (nIss < 2'h3) begin
                    bufRead <= 1'b1;
                    nIss    <= nIss + 2'h1;
                end else begin
                    bufRead <= 1'b0;
                end
                if (rdPrev && nGot == 2'h2) begin
                    busy     <= 1'b0;
                    evtCount <= evtCount + 8'h01;
                end
            end
        end
    end
endmodule : tpr_consumer_model
`default_nettype wire

/* File: tb/tpr_readout_top_bench.sv */
// Self-checking bench for the trigger pipeline and readout buffer.
`timescale 1ns/1ps
`default_nettype none
module tpr_readout_top_bench;
    import tpr_pkg::*;

    logic             sys_clk, rst, clearN, triggerAccept, accumEnable;
    logic             bufRead, bufEmpty, dataAvail, overflowOut, errorOut;
    logic             useCnt, en, slow, lostSeen, err;
    logic [127:0]     hitIn, bufData, accW;
    logic [2:0][127:0] evt;
    logic [7:0]       evtCount;
    logic [31:0]      cnt, rd;
    tpr_apb_req_t     apbReq;
    tpr_apb_rsp_t     apbRsp;
    logic [31:0]      stamps[$];
    int               failCount, nCompared;

    tpr_readout_top dut (.sys_clk(sys_clk), .rst(rst), .clearN(clearN),
        .hitIn(hitIn), .triggerAccept(triggerAccept),
        .accumEnable(accumEnable), .bufRead(bufRead), .bufData(bufData),
        .bufEmpty(bufEmpty), .dataAvail(dataAvail),
        .overflowOut(overflowOut), .errorOut(errorOut),
        .apbReq(apbReq), .apbRsp(apbRsp));

    tpr_consumer_model partner (.sys_clk(sys_clk), .rst(rst), .enable(en),
        .slow(slow), .dataAvail(dataAvail), .bufEmpty(bufEmpty),
        .overflowOut(overflowOut), .bufData(bufData), .bufRead(bufRead),
        .evt(evt), .evtCount(evtCount), .lostSeen(lostSeen));

    // ------------------------------------------------------------------
    // Clock, stamped hit stream and trigger bookkeeping
    // ------------------------------------------------------------------
    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cnt <= cnt + 32'h1;
        if (useCnt) hitIn <= {4{cnt + 32'h1}};
        if (triggerAccept && !accumEnable) stamps.push_back(cnt);
        if (stamps.size() > 8) void'(stamps.pop_front());
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic endOfTest;
        if (failCount == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : endOfTest

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic timeout;
        failCount++;
        endOfTest();
    endtask : timeout

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                    pwdata: wd};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        if (apbRsp.pready !== 1'b1) timeout();
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask : apb

    task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp,
                           input logic errExp);
        apb(1'b0, a, 32'h0);
        check({95'h0, err, rd}, {95'h0, errExp, exp});
    endtask : reg_chk

    task automatic flags(input logic [3:0] exp);
        check({124'h0, bufEmpty, dataAvail, overflowOut, errorOut},
              {124'h0, exp});
    endtask : flags

    task automatic trig(input logic acc);
        @(posedge sys_clk);
        triggerAccept <= 1'b1;
        accumEnable   <= acc;
        @(posedge sys_clk);
        triggerAccept <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask : trig

    task automatic get_evt(input logic slw);
        logic [7:0] target;
        int         n;
        target = evtCount + 8'h01;
        @(posedge sys_clk);
        en   <= 1'b1;
        slow <= slw;
        @(posedge sys_clk);
        en <= 1'b0;
        n = 0;
        while (evtCount !== target && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        if (evtCount !== target) timeout();
    endtask : get_evt

    task automatic chk_evt(input logic slw);
        logic [31:0] s;
        get_evt(slw);
        s = (stamps.size() > 0) ? stamps.pop_front() : 32'h0;
        check(evt[0], {4{s - 32'h5}});
        check(evt[1], {4{s - 32'h4}});
        check(evt[2], {4{s - 32'h3}});
    endtask : chk_evt

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 0; rst = 1; clearN = 1; hitIn = '0; cnt = '0;
        triggerAccept = 0; accumEnable = 0; apbReq = '0;
        useCnt = 1; en = 0; slow = 0; failCount = 0; nCompared = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        flags(4'b1000);
        reg_chk(OFS_CTRL, {31'h0, CTRL_TAKE_RST}, 1'b0);
        reg_chk(12'h100, 32'h0, 1'b1);
        apb(1'b1, OFS_STATUS, 32'hffffffff);
        reg_chk(OFS_STATUS, 32'h00000001, 1'b0);
        repeat (140) @(posedge sys_clk);
        trig(1'b0);
        flags(4'b0100);
        chk_evt(1'b0);
        flags(4'b1000);
        for (int i = 0; i < 9; i++) trig(1'b0);
        reg_chk(OFS_STATUS, 32'h00001816, 1'b0);
        chk_evt(1'b1);
        check({127'h0, lostSeen}, 128'h1);
        reg_chk(OFS_STATUS, 32'h00001502, 1'b0);
        for (int i = 0; i < 7; i++) chk_evt(i[0]);
        reg_chk(OFS_STATUS, 32'h00000001, 1'b0);
        for (int i = 0; i < 23; i++) trig(1'b0);
        reg_chk(OFS_STATUS, 32'h000018f6, 1'b0);
        trig(1'b0);
        flags(4'b0111);
        @(posedge sys_clk);
        clearN <= 1'b0;
        repeat (2) @(posedge sys_clk);
        clearN <= 1'b1;
        @(posedge sys_clk);
        flags(4'b1001);
        apb(1'b1, OFS_CTRL, 32'h3);
        repeat (3) @(posedge sys_clk);
        flags(4'b1000);
        stamps.delete();
        useCnt <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0);
        hitIn  <= '0;
        clearN <= 1'b0;
        repeat (2) @(posedge sys_clk);
        clearN <= 1'b1;
        reg_chk(OFS_PTRS, 32'h0, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h1);
        reg_chk(OFS_ACC0, 32'h0, 1'b0);
        accW = {32'h00008000, 64'h0, 32'h01000013};
        hitIn <= {32'h00008000, 64'h0, 32'h00000011};
        @(posedge sys_clk);
        hitIn <= {96'h0, 32'h01000002};
        @(posedge sys_clk);
        hitIn <= '0;
        repeat (8) @(posedge sys_clk);
        reg_chk(OFS_ACC0, accW[31:0], 1'b0);
        reg_chk(OFS_ACC3, accW[127:96], 1'b0);
        trig(1'b1);
        get_evt(1'b0);
        for (int i = 0; i < 3; i++) check(evt[i], accW);
        apb(1'b1, OFS_CTRL, 32'h3);
        repeat (3) @(posedge sys_clk);
        reg_chk(OFS_ACC0, 32'h0, 1'b0);
        endOfTest();
    end
endmodule : tpr_readout_top_bench
`default_nettype wire
